// [hw/rcs_pkg.sv]
// package: register map, field layout, pin timing and state types for the config port host
package rcs_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int WORD_W = 20;
  localparam int CNT_W = 8;

  localparam logic [2:0] IDX_CTRL = 3'h0;
  localparam logic [2:0] IDX_WORD = 3'h1;
  localparam logic [2:0] IDX_STATUS = 3'h2;
  localparam logic [2:0] IDX_SENT = 3'h3;

  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_NBITS_LSB = 8;
  localparam int CTRL_SQUELCH_BIT = 16;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_ERR_BIT = 2;
  localparam int STAT_PIN_BIT = 3;

  localparam int W_AGC_BIT = 19;
  localparam int W_WDOG_BIT = 18;
  localparam int W_SQUELCH_BIT = 17;
  localparam int W_RSV_BIT = 16;
  localparam int W_LOW_BIT = 0;

  localparam logic [19:0] WORD_RST = 20'h42e78;
  localparam logic [4:0] NBITS_RST = 5'h14;
  localparam logic [4:0] NBITS_MAX = 5'h14;
  localparam logic SQUELCH_RST = 1'b1;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int CLK_NS = 5;
  localparam int MIN_PHASE_NS = 100;
  localparam int PHASE_NS = 250;
  localparam int PHASE_CYC = (PHASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int MIN_PHASE_CYC = (MIN_PHASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCLK_MIN_HZ = 5000;
  localparam int MAX_PERIOD_CYC = (1000000000 / SCLK_MIN_HZ) / CLK_NS;

  typedef enum logic [3:0] {
    ST_IDLE, ST_CLK_HI, ST_DRV_LO, ST_CLK_LO, ST_CLK_HI2, ST_D_HI, ST_D_LO,
    ST_BIT_LO, ST_BIT_HI, ST_STOP_LO, ST_STOP_HI, ST_STOP_LO2, ST_END
  } rcs_state_t;
endpackage : rcs_pkg

// [hw/rcs_host.sv]
// host controller that programs the receiver config word over the clock and data pins
//
// Overview of operation
// - bit 18 always sent as one, bits 19 and 16 as zero
// - squelch pin and bit 17 differ; default pin high, bit zero
// - programming uses only clock and data pins; data pin normally device output
// - clock high tri-states device data pin; host then drives it low
// - start: clock low then high with data low, then data high then low
// - serial clock kept faster than 5kHz or device resets its port
// - bits sent most significant first, one per clock, ending at bit 0
// - partial write sends bit N down to bit 0 only
// - stop: clock high, data low-high-low, then clock low releases data pin
// - select pins and squelch pin kept high while programming
// - every clock phase and interval longer than 0.1 us; the phase check accepts a phase of exactly 0.1 us
// - continuous receive needs a fresh write to re-enter auto-poll
//
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module rcs_host #(
  parameter int PHASE_CYCLES = rcs_pkg::PHASE_CYC
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [rcs_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [rcs_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [rcs_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [rcs_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic sclkPin,
  input wire logic dataPinIn,
  output logic dataPinOut,
  output logic dataPinOe,
  output logic squelchPin,
  output logic parallelSelect0,
  output logic parallelSelect1
);
  import rcs_pkg::*;

  // phase must honour the 0.1 us floor and keep the clock above 5kHz
  // refused at elaboration: the phase counter is only CNT_W bits wide
  if (PHASE_CYCLES < MIN_PHASE_CYC || PHASE_CYCLES >= 256 || 2 * PHASE_CYCLES > MAX_PERIOD_CYC) begin : g_bad_phase
    $error("rcs_host: PHASE_CYCLES out of range");
  end

  localparam logic [CNT_W-1:0] PH_LAST = CNT_W'(PHASE_CYCLES - 1);

  typedef struct packed {
    rcs_state_t st;
    logic [CNT_W-1:0] phCnt;
    logic [4:0] bitsLeft;
    logic [WORD_W-1:0] shift;
    logic sclk;
    logic dOut;
    logic dOe;
    logic squelch;
    logic sel;
    logic dSync1;
    logic dSync2;
    logic [WORD_W-1:0] word;
    logic [WORD_W-1:0] sent;
    logic [4:0] nbits;
    logic squelchLvl;
    logic done;
    logic err;
    logic awGot;
    logic [ADDR_W-1:0] awAddr;
    logic wGot;
    logic [DATA_W-1:0] wData;
    logic [3:0] wStrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } rcs_regs_t;

  localparam rcs_regs_t RST_STATE = '{
    st: ST_IDLE, phCnt: '0, bitsLeft: '0, shift: '0, sclk: 1'b0, dOut: 1'b0, dOe: 1'b0,
    squelch: SQUELCH_RST, sel: 1'b1, dSync1: 1'b0, dSync2: 1'b0, word: WORD_RST, sent: '0,
    nbits: NBITS_RST, squelchLvl: SQUELCH_RST, done: 1'b0, err: 1'b0, awGot: 1'b0, awAddr: '0,
    wGot: 1'b0, wData: '0, wStrb: '0, awready: 1'b1, wready: 1'b1, bvalid: 1'b0,
    bresp: RESP_OKAY, arready: 1'b1, rvalid: 1'b0, rdata: '0, rresp: RESP_OKAY
  };

  rcs_regs_t s_q;
  rcs_regs_t s_d;

  // merge write data into an old value under byte strobes
  function automatic logic [DATA_W-1:0] applyStrb(input logic [DATA_W-1:0] old,
                                                   input logic [DATA_W-1:0] data,
                                                   input logic [3:0] strb);
    logic [DATA_W-1:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    return res;
  endfunction : applyStrb

  // fixed bits are forced so software cannot send an unsafe word
  function automatic logic [WORD_W-1:0] fixWord(input logic [WORD_W-1:0] w, input logic squelchLvl);
    logic [WORD_W-1:0] f;
    f = w;
    f[W_AGC_BIT] = 1'b0;
    f[W_WDOG_BIT] = 1'b1;
    f[W_RSV_BIT] = 1'b0;
    f[W_SQUELCH_BIT] = ~squelchLvl;
    f[W_LOW_BIT] = 1'b0;
    return f;
  endfunction : fixWord

  // pin levels {sclk, oe, data} that each state presents
  function automatic logic [2:0] pinsFor(input rcs_state_t st, input logic bitVal);
    logic [2:0] p;
    p = 3'h0;
    case (st)
      ST_IDLE: p = 3'h0;
      ST_CLK_HI: p = 3'h4;
      ST_DRV_LO: p = 3'h6;
      ST_CLK_LO: p = 3'h2;
      ST_CLK_HI2: p = 3'h6;
      ST_D_HI: p = 3'h7;
      ST_D_LO: p = 3'h6;
      ST_BIT_LO: p = {2'h1, bitVal};
      ST_BIT_HI: p = {2'h3, bitVal};
      ST_STOP_LO: p = 3'h6;
      ST_STOP_HI: p = 3'h7;
      ST_STOP_LO2: p = 3'h6;
      ST_END: p = 3'h0;
      default: p = 3'h0;
    endcase
    return p;
  endfunction : pinsFor

  always_comb begin
    logic [DATA_W-1:0] mrg;
    logic [DATA_W-1:0] rd;
    logic [2:0] pins;
    logic startReq;
    logic doneSet;
    logic errSet;
    logic doneClr;
    logic errClr;
    mrg = '0;
    rd = '0;
    pins = 3'h0;
    startReq = 1'b0;
    doneSet = 1'b0;
    errSet = 1'b0;
    doneClr = 1'b0;
    errClr = 1'b0;
    s_d = s_q;

    // pin input passes two flops before anything reads it
    s_d.dSync1 = dataPinIn;
    s_d.dSync2 = s_q.dSync1;

    // write channels: address and data taken in either order
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_axi_awvalid && s_q.awready) begin
      s_d.awGot = 1'b1;
      s_d.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.wGot = 1'b1;
      s_d.wData = s_axi_wdata;
      s_d.wStrb = s_axi_wstrb;
    end
    if (s_d.awGot && s_d.wGot && !s_d.bvalid) begin
      s_d.awGot = 1'b0;
      s_d.wGot = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      case (s_d.awAddr[ADDR_W-1:2])
        IDX_CTRL: begin
          mrg = applyStrb({15'h0, s_q.squelchLvl, 3'h0, s_q.nbits, 8'h0}, s_d.wData, s_d.wStrb);
          s_d.squelchLvl = mrg[CTRL_SQUELCH_BIT];
          s_d.nbits = mrg[CTRL_NBITS_LSB +: 5];
          startReq = mrg[CTRL_START_BIT];
        end
        IDX_WORD: begin
          // a fresh word is how software leaves continuous receive
          mrg = applyStrb({12'h0, s_q.word}, s_d.wData, s_d.wStrb);
          s_d.word = mrg[WORD_W-1:0];
        end
        IDX_STATUS: begin
          doneClr = s_d.wStrb[0] & s_d.wData[STAT_DONE_BIT];
          errClr = s_d.wStrb[0] & s_d.wData[STAT_ERR_BIT];
        end
        IDX_SENT: begin
          s_d.bresp = RESP_SLVERR;
        end
        default: begin
          s_d.bresp = RESP_SLVERR;
        end
      endcase
    end

    // serial sequencer, each state other than ST_IDLE holds for one phase
    if (s_q.st == ST_IDLE) begin
      s_d.phCnt = '0;
      if (startReq) begin
        if (s_d.nbits == 5'h0 || s_d.nbits > NBITS_MAX) begin
          errSet = 1'b1;
        end else begin
          // partial write: only bit nbits-1 down to bit 0 leave the shifter
          s_d.shift = WORD_W'(fixWord(s_d.word, s_d.squelchLvl) << (5'(WORD_W) - s_d.nbits));
          s_d.sent = fixWord(s_d.word, s_d.squelchLvl);
          s_d.bitsLeft = s_d.nbits;
          s_d.st = ST_CLK_HI;
        end
      end
    end else begin
      if (startReq) begin
        errSet = 1'b1;
      end
      if (s_q.phCnt != PH_LAST) begin
        s_d.phCnt = s_q.phCnt + CNT_W'(1);
      end else begin
        s_d.phCnt = '0;
        case (s_q.st)
          ST_CLK_HI: s_d.st = ST_DRV_LO;
          ST_DRV_LO: s_d.st = ST_CLK_LO;
          ST_CLK_LO: s_d.st = ST_CLK_HI2;
          ST_CLK_HI2: s_d.st = ST_D_HI;
          ST_D_HI: s_d.st = ST_D_LO;
          ST_D_LO: s_d.st = ST_BIT_LO;
          ST_BIT_LO: s_d.st = ST_BIT_HI;
          ST_BIT_HI: begin
            if (s_q.bitsLeft == 5'h1) begin
              s_d.st = ST_STOP_LO;
            end else begin
              s_d.bitsLeft = s_q.bitsLeft - 5'h1;
              s_d.shift = {s_q.shift[WORD_W-2:0], 1'b0};
              s_d.st = ST_BIT_LO;
            end
          end
          ST_STOP_LO: s_d.st = ST_STOP_HI;
          ST_STOP_HI: s_d.st = ST_STOP_LO2;
          ST_STOP_LO2: s_d.st = ST_END;
          ST_END: begin
            s_d.st = ST_IDLE;
            doneSet = 1'b1;
          end
          default: s_d.st = ST_IDLE;
        endcase
      end
    end

    // pins follow the next state so they change with it in the same edge
    pins = pinsFor(s_d.st, s_d.shift[WORD_W-1]);
    s_d.sclk = pins[2];
    s_d.dOe = pins[1];
    s_d.dOut = pins[0];
    // squelch held high while programming, else the chosen level
    s_d.squelch = (s_d.st != ST_IDLE) ? 1'b1 : s_d.squelchLvl;
    s_d.sel = 1'b1;

    // set wins over a clear in the same cycle
    s_d.done = (s_q.done & ~doneClr) | doneSet;
    s_d.err = (s_q.err & ~errClr) | errSet;

    // read channel
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      case (s_axi_araddr[ADDR_W-1:2])
        IDX_CTRL: rd = {15'h0, s_q.squelchLvl, 3'h0, s_q.nbits, 8'h0};
        IDX_WORD: rd = {12'h0, s_q.word};
        IDX_STATUS: begin
          rd[STAT_BUSY_BIT] = (s_q.st != ST_IDLE);
          rd[STAT_DONE_BIT] = s_q.done;
          rd[STAT_ERR_BIT] = s_q.err;
          rd[STAT_PIN_BIT] = s_q.dSync2;
        end
        IDX_SENT: rd = {12'h0, s_q.sent};
        default: begin
          rd = '0;
          s_d.rresp = RESP_SLVERR;
        end
      endcase
      s_d.rdata = rd;
    end

    s_d.awready = !s_d.awGot && !s_d.bvalid;
    s_d.wready = !s_d.wGot && !s_d.bvalid;
    s_d.arready = !s_d.rvalid;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= RST_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign sclkPin = s_q.sclk;
  assign dataPinOut = s_q.dOut;
  assign dataPinOe = s_q.dOe;
  assign squelchPin = s_q.squelch;
  assign parallelSelect0 = s_q.sel;
  assign parallelSelect1 = s_q.sel;
endmodule : rcs_host

// [test/rcs_host_chk_sva.sv]
// checker: serial pin timing and bus refusal of the config port host
`timescale 1ns/1ps
module rcs_host_chk
  import rcs_pkg::*;
#(
  parameter int PHASE_CYCLES = 20
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic sclkPin,
  input wire logic dataPinOut,
  input wire logic dataPinOe,
  input wire logic squelchPin,
  input wire logic parallelSelect0,
  input wire logic parallelSelect1
);
  logic [15:0] runQ;
  logic [15:0] sclkRunQ;
  logic [1:0] prevQ;
  // counters saturate so a long idle never wraps into a short phase
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      runQ <= 16'hffff;
      sclkRunQ <= 16'h0;
      prevQ <= 2'h0;
    end else begin
      prevQ <= {sclkPin, dataPinOut};
      runQ <= ({sclkPin, dataPinOut} != prevQ) ? 16'h0 : ((runQ == 16'hffff) ? runQ : runQ + 16'h1);
      sclkRunQ <= (sclkPin != prevQ[1]) ? 16'h0 : ((sclkRunQ == 16'hffff) ? sclkRunQ : sclkRunQ + 16'h1);
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  chk_sel_high: assert property (parallelSelect0 && parallelSelect1) else $error("select low");
  chk_squelch_prog: assert property (dataPinOe |-> squelchPin) else $error("squelch low");
  chk_oe_rise: assert property ($rose(dataPinOe) |-> sclkPin && $past(sclkPin) && !dataPinOut)
    else $error("drive without clock high");
  chk_phase_min: assert property ($changed({sclkPin, dataPinOut}) |-> runQ >= 16'(MIN_PHASE_CYC - 1))
    else $error("phase too short");
  chk_clk_stall: assert property (dataPinOe |-> sclkRunQ < 16'(4 * PHASE_CYCLES))
    else $error("clock stalled");
  chk_data_edge: assert property ($rose(dataPinOut) && dataPinOe && sclkPin |-> $past(sclkPin, PHASE_CYCLES))
    else $error("data moved with clock high");
  chk_stop_seq: assert property ($fell(dataPinOe) |->
    $fell(sclkPin) && !$past(dataPinOut) && $past(dataPinOut, PHASE_CYCLES + 1)) else $error("bad stop");
  chk_bus_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write while busy");
endmodule : rcs_host_chk
bind rcs_host rcs_host_chk #(.PHASE_CYCLES(PHASE_CYCLES)) i_rcs_host_chk (.mclk, .sys_rst, .s_axi_awready,
  .s_axi_wready, .s_axi_bvalid, .sclkPin, .dataPinOut, .dataPinOe, .squelchPin, .parallelSelect0, .parallelSelect1);

// [test/rcs_dev_model.sv]
// device model: two-wire config port of the receiver and its data pin
`timescale 1ns/1ps
module rcs_dev_model (
  input wire logic sclk,
  input wire logic hostOe,
  input wire logic hostOut,
  output wire logic pin
);
  logic [19:0] word = 20'h0;
  logic [19:0] sh = 20'h0;
  logic [19:0] m;
  logic last = 1'b1;
  int st = 0;
  int cnt = 0;
  realtime tEdge = 0.0;
  // idle pin held low while polling waits for valid bits; no carrier is modelled
  wire pollHold = word[15] && word[8:7] != 2'h0;
  // a released pin, unless idle with clock low, shows the inverse of its last driven level
  assign pin = hostOe ? hostOut : (!sclk && st == 0) ? ~pollHold : ~last;
  always @(pin) if (hostOe || (!sclk && st == 0)) last = pin;
  always @(posedge sclk) begin
    if ($realtime - tEdge > 200000.0) st = 0;
    tEdge = $realtime;
    if (st == 1) st = 2;
    else if (st == 4) begin
      sh = {sh[18:0], pin};
      cnt++;
    end
  end
  // judged 1 ns late so a release in the same step as the clock fall is settled
  always @(negedge sclk) #1 if (st <= 2 && hostOe && pin === 1'b0) st = 1;
  // pin edges judged 1 ns late so a clock edge in the same step is settled
  always @(posedge pin) #1 if (sclk) begin
    if (st == 2) st = 3;
    else if (st == 4) st = 5;
  end
  always @(negedge pin) #1 if (sclk) begin
    if (st == 3) begin
      st = 4;
      cnt = 0;
    end else if (st == 5) begin
      m = 20'((21'h1 << cnt) - 21'h1);
      word = (word & ~m) | (sh & m);
      st = 0;
    end
  end
endmodule : rcs_dev_model

// [test/rcs_host_tb.sv]
// testbench: bus stimulus and expected words for the config port host
`timescale 1ns/1ps
module rcs_host_tb;
  import rcs_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [4:0] s_axi_awaddr = 5'h0, s_axi_araddr = 5'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic sclkPin, dataPinIn, dataPinOut, dataPinOe, squelchPin, parallelSelect0, parallelSelect1;
  int errors = 0, check_count = 0, cycles = 0;
  int nTab[6] = '{20, 20, 3, 18, 1, 20};
  logic [19:0] devExp;
  logic [31:0] pinExp = 32'h8;
  logic [3:0] s_axi_wstrb = 4'hf;
  always #2.5 mclk = ~mclk;
  rcs_host #(.PHASE_CYCLES(20)) i_rcs_host (.mclk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .sclkPin, .dataPinIn, .dataPinOut, .dataPinOe, .squelchPin, .parallelSelect0, .parallelSelect1);
  rcs_dev_model i_rcs_dev_model (.sclk(sclkPin), .hostOe(dataPinOe), .hostOut(dataPinOut), .pin(dataPinIn));
  task automatic complete_run();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run
  always @(posedge mclk) if (++cycles == 60000) begin
    errors++;
    complete_run();
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w) begin
      @(posedge mclk);
      if (s_axi_awready) aw = 1'b0;
      if (s_axi_wready) w = 1'b0;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
    @(posedge mclk);
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge mclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge mclk);
  endtask : rd
  task automatic rc(input logic [4:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e);
    chk({30'h0, r}, {30'h0, er});
  endtask : rc
  task automatic wait_done(output logic [31:0] d);
    logic [1:0] r;
    d = 32'h0;
    while (d[1] !== 1'b1) rd(5'h08, d, r);
  endtask : wait_done
  task automatic xfer(input logic [19:0] w, input logic squelchLvl, input int n);
    logic [31:0] d;
    logic [1:0] r;
    logic [19:0] m;
    logic [19:0] e;
    m = 20'((21'h1 << n) - 21'h1);
    e = (w & 20'h0fffe) | 20'h40000 | (squelchLvl ? 20'h0 : 20'h20000);
    wr(5'h04, {12'h0, w}, RESP_OKAY);
    wr(5'h00, {15'h0, squelchLvl, 3'h0, n[4:0], 8'h1}, RESP_OKAY);
    wait_done(d);
    rd(5'h0c, d, r);
    chk({12'h0, d[19:0]}, {12'h0, e});
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    devExp = (devExp & ~m) | (e & m);
    pinExp = (devExp[15] && devExp[8:7] != 2'h0) ? 32'h0 : 32'h8;
    chk({12'h0, i_rcs_dev_model.word}, {12'h0, devExp});
    chk({31'h0, squelchPin}, {31'h0, squelchLvl});
    wr(5'h08, 32'h2, RESP_OKAY);
    rc(5'h08, pinExp, RESP_OKAY);
  endtask : xfer
  initial begin
    logic [31:0] d;
    void'($urandom(32'h0418));
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    rc(5'h00, 32'h00011400, RESP_OKAY);
    rc(5'h04, 32'h00042e78, RESP_OKAY);
    // only byte lane 2 lands; of the fixed bits it sets, 19, 17 and 16 are forced off when sent and 18 stays one
    s_axi_wstrb <= 4'h4;
    wr(5'h04, 32'h00ff1234, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rc(5'h04, 32'h000f2e78, RESP_OKAY);
    rc(5'h08, 32'h8, RESP_OKAY);
    rc(5'h10, 32'h0, RESP_SLVERR);
    wr(5'h0c, 32'h1, RESP_SLVERR);
    rc(5'h0c, 32'h0, RESP_OKAY);
    // start while busy is refused but the running word still completes
    wr(5'h00, 32'h00011401, RESP_OKAY);
    wr(5'h00, 32'h00011401, RESP_OKAY);
    wait_done(d);
    chk(d, 32'he);
    devExp = 20'h42e78;
    chk({12'h0, i_rcs_dev_model.word}, {12'h0, devExp});
    wr(5'h08, 32'h6, RESP_OKAY);
    foreach (nTab[i]) xfer(20'($urandom), 1'($urandom), nTab[i]);
    wr(5'h00, 32'h00010001, RESP_OKAY);
    rc(5'h08, pinExp | 32'h4, RESP_OKAY);
    wr(5'h08, 32'h4, RESP_OKAY);
    wr(5'h00, 32'h00011501, RESP_OKAY);
    rc(5'h08, pinExp | 32'h4, RESP_OKAY);
    complete_run();
  end
endmodule : rcs_host_tb
